// ==== hdl/ccd_clocking_sequencer.sv ====
// Camera-side clock sequencer driving the full-frame sensor phase pins
// Behaviour
// R01: Both vertical phases held low, no toggling, during integration.
// R02: Line moves to horizontal register on vertical two fall; phase one A high.
// R03: Parallel split shifts line through transfer gate into B; split reads at once.
// R04: Each line splits at midpoint; left and right halves read on separate outputs; only the left output (SAMPLE_LEFT) is sampled here.
// R05: Each last-gate falling edge delivers one pixel to the sampler.
// R06: Flush raises vertical two with one low; purge or dump only while two high.
// R07: Flush done only after vertical two low plus settling; then exposure.
// R08: Fast dump row drained through the separate dump gate.
// R09: After sampling a pixel, reset gate pulses before next packet.
// R10: Twenty leading dummy pixels excluded from dark reference.
// R11: Sixteen buffer pixels between active area and dark reference.
// R12: Colour parts: first four buffer columns blue, then Bayer order.
// R13: Two test columns per output and one test row, test only.
// R14: Lower output level means brighter pixel; sample is inverted.
// R15: 28 dark pixels per line; 29 leading, 26 trailing dark lines.
// R16: Programmable pixel and line counters sequence clocks and flag regions.
`timescale 1ns/1ps
`include "ccd_params.svh"
module ccd_clocking_sequencer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32,
    parameter logic [31:0] SETTLE = `SETTLE_CYC
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic START,
    input wire logic PARALLEL,
    input wire logic [31:0] INT_CYCLES,
    input wire logic [15:0] LINE_PIX,
    input wire logic [15:0] FRAME_LINES,
    input wire logic [WIDTH-1:0] SAMPLE_LEFT,
    input wire logic SAMPLE_VALID,
    output logic VERTICAL_PHASE_ONE,
    output logic VERTICAL_PHASE_TWO,
    output logic HORIZ_PHASE_ONE_A,
    output logic HORIZ_PHASE_ONE_B,
    output logic HORIZ_PHASE_TWO,
    output logic LAST_HORIZONTAL_GATE,
    output logic HORIZONTAL_TRANSFER_GATE,
    output logic PULSE_PURGE_GATE,
    output logic FAST_DUMP_GATE,
    output logic FLOATING_NODE_RESET,
    output logic PIXEL_STROBE,
    output logic [1:0] REGION,
    output logic DARK_LINE,
    output logic BUSY,
    output logic [WIDTH-1:0] PIX_DATA,
    output logic PIX_VALID,
    input wire logic PIX_READY
);
    ccd_pkg::seq_e st_q, st_d;
    logic [31:0] tmr_q, tmr_d;
    logic [15:0] pix_q, pix_d, line_q, line_d;
    logic v1_q, v1_d, v2_q, v2_d, h1_q, h1_d, xg_q, xg_d, pg_q, pg_d, fd_q, fd_d;
    logic rg_q, rg_d;
    logic pend_q, pend_d;
    logic [1:0] reg_q, reg_d;
    logic dl_q, dl_d;
    logic fifo_ready;
    logic [15:0] half;

    function automatic logic [1:0] region_of(input logic [15:0] p);
        if (p < `DUMMY_PIX) begin
            region_of = ccd_pkg::RG_DUMMY; // R10
        end else if (p < `DUMMY_PIX + `DARK_PIX) begin
            region_of = ccd_pkg::RG_DARK; // R15
        end else if (p < `DUMMY_PIX + `DARK_PIX + `BUFFER_PIX) begin
            region_of = ccd_pkg::RG_BUFFER; // R11 R12
        end else begin
            region_of = ccd_pkg::RG_ACTIVE;
        end
    endfunction : region_of

    // Each output sees half of a line
    assign half = {1'b0, LINE_PIX[15:1]}; // R04

    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q;
        pix_d = pix_q;
        line_d = line_q;
        v1_d = v1_q;
        v2_d = v2_q;
        h1_d = h1_q;
        xg_d = 1'b0;
        pg_d = 1'b0;
        fd_d = 1'b0;
        rg_d = 1'b0;
        reg_d = reg_q;
        dl_d = dl_q;
        pend_d = pend_q;
        // Front end answers a pixel late, so the FIFO count alone lags by one sample
        if (SAMPLE_VALID) begin
            pend_d = 1'b0;
        end
        case (st_q)
            ccd_pkg::ST_IDLE: begin
                v1_d = 1'b0;
                v2_d = 1'b0;
                if (START) begin
                    st_d = ccd_pkg::ST_FL_V2;
                    v2_d = 1'b1; // R06
                    tmr_d = 32'(`VPHASE_CYC);
                end
            end
            ccd_pkg::ST_FL_V2: begin
                if (tmr_q == 32'h0000_0001) begin
                    st_d = ccd_pkg::ST_FL_PG;
                    tmr_d = 32'(`PURGE_CYC);
                end else begin
                    tmr_d = tmr_q - 32'h0000_0001;
                end
            end
            ccd_pkg::ST_FL_PG: begin
                pg_d = (tmr_q != 32'h0000_0001) && v2_q; // R06
                fd_d = (tmr_q != 32'h0000_0001) && v2_q; // R08
                if (tmr_q == 32'h0000_0001) begin
                    st_d = ccd_pkg::ST_FL_V2LO;
                end else begin
                    tmr_d = tmr_q - 32'h0000_0001;
                end
            end
            ccd_pkg::ST_FL_V2LO: begin
                v2_d = 1'b0;
                st_d = ccd_pkg::ST_FL_SET;
                tmr_d = SETTLE; // R07
            end
            ccd_pkg::ST_FL_SET: begin
                if (tmr_q <= 32'h0000_0001) begin
                    st_d = ccd_pkg::ST_INT; // R07
                    tmr_d = (INT_CYCLES == '0) ? 32'h0000_0001 : INT_CYCLES;
                end else begin
                    tmr_d = tmr_q - 32'h0000_0001;
                end
            end
            ccd_pkg::ST_INT: begin
                v1_d = 1'b0; // R01
                v2_d = 1'b0; // R01
                if (tmr_q == 32'h0000_0001) begin
                    st_d = ccd_pkg::ST_V1;
                    line_d = '0;
                end else begin
                    tmr_d = tmr_q - 32'h0000_0001;
                end
            end
            ccd_pkg::ST_V1: begin
                v1_d = 1'b1;
                h1_d = 1'b1; // R02
                st_d = ccd_pkg::ST_V2;
                dl_d = (line_q < `DARK_LINES_START) ||
                       (line_q + `DARK_LINES_END >= FRAME_LINES); // R15
            end
            ccd_pkg::ST_V2: begin
                v1_d = 1'b0;
                v2_d = 1'b1;
                st_d = ccd_pkg::ST_V2F;
            end
            ccd_pkg::ST_V2F: begin
                v2_d = 1'b0; // R02
                pix_d = '0;
                // Parallel split passes the line to B through the transfer gate; B is then read at once
                st_d = PARALLEL ? ccd_pkg::ST_XFER : ccd_pkg::ST_HPIX; // R03
            end
            ccd_pkg::ST_XFER: begin
                xg_d = 1'b1; // R03
                st_d = ccd_pkg::ST_HPIX;
            end
            ccd_pkg::ST_HPIX: begin
                // Stall while the sample buffer is full so no pixel is lost
                // Limitation: a front end that never answers stalls the line
                if (fifo_ready && !pend_q) begin
                    h1_d = 1'b0; // R05
                    pend_d = 1'b1;
                    reg_d = region_of(pix_q); // R16
                    st_d = ccd_pkg::ST_RST;
                end
            end
            ccd_pkg::ST_RST: begin
                h1_d = 1'b1;
                rg_d = 1'b1; // R09
                if (pix_q + 16'h0001 >= half) begin
                    line_d = line_q + 16'h0001; // R16
                    st_d = (line_q + 16'h0001 >= FRAME_LINES) ?
                           ccd_pkg::ST_IDLE : ccd_pkg::ST_V1;
                end else begin
                    pix_d = pix_q + 16'h0001;
                    st_d = ccd_pkg::ST_HPIX;
                end
            end
            default: st_d = ccd_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st_q <= ccd_pkg::ST_IDLE;
            tmr_q <= '0;
            pix_q <= '0;
            line_q <= '0;
            v1_q <= 1'b0;
            v2_q <= 1'b0;
            h1_q <= 1'b1;
            xg_q <= 1'b0;
            pg_q <= 1'b0;
            fd_q <= 1'b0;
            rg_q <= 1'b0;
            reg_q <= ccd_pkg::RG_DUMMY;
            dl_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            pix_q <= pix_d;
            line_q <= line_d;
            v1_q <= v1_d;
            v2_q <= v2_d;
            h1_q <= h1_d;
            xg_q <= xg_d;
            pg_q <= pg_d;
            fd_q <= fd_d;
            rg_q <= rg_d;
            reg_q <= reg_d;
            dl_q <= dl_d;
            pend_q <= pend_d;
        end
    end

    assign VERTICAL_PHASE_ONE = v1_q;
    assign VERTICAL_PHASE_TWO = v2_q;
    assign HORIZ_PHASE_ONE_A = h1_q;
    assign HORIZ_PHASE_ONE_B = h1_q;
    assign HORIZ_PHASE_TWO = ~h1_q;
    assign LAST_HORIZONTAL_GATE = h1_q;
    assign HORIZONTAL_TRANSFER_GATE = xg_q;
    assign PULSE_PURGE_GATE = pg_q;
    assign FAST_DUMP_GATE = fd_q;
    assign FLOATING_NODE_RESET = rg_q;
    assign PIXEL_STROBE = (st_q == ccd_pkg::ST_RST); // R05
    assign REGION = reg_q;
    assign DARK_LINE = dl_q;
    assign BUSY = (st_q != ccd_pkg::ST_IDLE);

    ccd_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clk(MCLK),
        .rst(RESET),
        .in_data(~SAMPLE_LEFT), // R14
        .in_valid(SAMPLE_VALID),
        .in_ready(fifo_ready),
        .out_data(PIX_DATA),
        .out_valid(PIX_VALID),
        .out_ready(PIX_READY)
    );

    a_int_vert_low: assert property (@(posedge MCLK) disable iff (RESET)
        st_q == ccd_pkg::ST_INT |-> !v1_q && !v2_q) // R01
        else $error("vertical phase active in integration");
    a_xfer_h1_high: assert property (@(posedge MCLK) disable iff (RESET)
        $fell(v2_q) && st_q != ccd_pkg::ST_FL_SET |-> h1_q) // R02
        else $error("phase one A low at line transfer");
    a_purge_v2_high: assert property (@(posedge MCLK) disable iff (RESET)
        pg_q || fd_q |-> v2_q && !v1_q) // R06
        else $error("purge without vertical two high");
    a_settle_wait: assert property (@(posedge MCLK) disable iff (RESET)
        st_q == ccd_pkg::ST_FL_V2LO |=> !v2_q [*2]) // R07
        else $error("settle not started with vertical two low");
    a_reset_after_pix: assert property (@(posedge MCLK) disable iff (RESET)
        $fell(h1_q) |=> rg_q) // R09
        else $error("reset gate missing after pixel");
    a_xg_parallel: assert property (@(posedge MCLK) disable iff (RESET)
        xg_q |-> $past(st_q) == ccd_pkg::ST_XFER) // R03
        else $error("transfer gate outside parallel step");
    a_strobe_pix: assert property (@(posedge MCLK) disable iff (RESET)
        PIXEL_STROBE |-> $past(h1_q) && !h1_q) // R05
        else $error("strobe without last gate fall");
    a_dummy_region: assert property (@(posedge MCLK) disable iff (RESET)
        st_q == ccd_pkg::ST_RST && pix_q < `DUMMY_PIX |-> reg_q == ccd_pkg::RG_DUMMY) // R10
        else $error("dummy pixel not flagged");
    a_sample_room: assert property (@(posedge MCLK) disable iff (RESET)
        SAMPLE_VALID |-> fifo_ready) // R05
        else $error("sample arrived with buffer full");
endmodule : ccd_clocking_sequencer

// ==== shared/ccd_params.svh ====
// Timing counts and geometry constants for the sensor clock sequencer
`ifndef CCD_PARAMS_SVH
`define CCD_PARAMS_SVH
`define DUMMY_PIX 16'h0014
`define DARK_PIX 16'h001C
`define BUFFER_PIX 16'h0010
`define BLUE_BUF_PIX 16'h0004
`define TEST_COLS 16'h0002
`define DARK_LINES_START 16'h001D
`define DARK_LINES_END 16'h001A
`define LINE_PIX_DEF 16'h1038
`define FRAME_LINES_DEF 16'h1844
`define SETTLE_NS 32'd10000
`define CLK_NS 32'd100
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 32'd1) / `CLK_NS)
`define PURGE_CYC 16'h0008
`define VPHASE_CYC 16'h0004
`endif

// ==== shared/ccd_pkg.sv ====
// Types for the sensor clock sequencer
package ccd_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_FL_V2 = 4'b0001,
        ST_FL_PG = 4'b0010,
        ST_FL_V2LO = 4'b0011,
        ST_FL_SET = 4'b0100,
        ST_INT = 4'b0101,
        ST_V1 = 4'b0110,
        ST_V2 = 4'b0111,
        ST_V2F = 4'b1000,
        ST_XFER = 4'b1001,
        ST_HPIX = 4'b1010,
        ST_RST = 4'b1011
    } seq_e;
    typedef enum logic [1:0] {
        RG_DUMMY = 2'b00,
        RG_DARK = 2'b01,
        RG_BUFFER = 2'b10,
        RG_ACTIVE = 2'b11
    } region_e;
endpackage : ccd_pkg

// ==== hdl/ccd_fifo.sv ====
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module ccd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic wr, rd;
    always_comb begin
        in_ready = (cnt_q != DEPTH[AW:0]);
        out_valid = (cnt_q != '0);
        out_data = mem_q[rp_q];
        wr = in_valid && in_ready;
        rd = out_valid && out_ready;
        wp_d = wr ? wp_q + 1'b1 : wp_q;
        rp_d = rd ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
        if (wr) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule : ccd_fifo

// ==== verification/ccd_sensor_model.sv ====
// Behavioural sensor output and front end: one sample per last-gate fall
`timescale 1ns/1ps
module ccd_sensor_model (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic LAST_HORIZONTAL_GATE,
    output logic [15:0] SAMPLE_LEFT,
    output logic SAMPLE_VALID
);
    logic gate_q;
    logic fell;
    logic [15:0] charge_q;
    initial begin
        gate_q = 1'b1;
        fell = 1'b0;
        charge_q = 16'h0000;
        SAMPLE_LEFT = 16'hffff;
        SAMPLE_VALID = 1'b0;
    end
    // Left output only; the right half of each line is not digitised here
    always @(posedge MCLK) begin
        fell = gate_q && !LAST_HORIZONTAL_GATE;
        gate_q = LAST_HORIZONTAL_GATE;
        #1;
        SAMPLE_VALID = 1'b0;
        // Idle bus toggles so a stale value never passes as a sample
        SAMPLE_LEFT = ~SAMPLE_LEFT;
        if (RESET) begin
            charge_q = 16'h0000;
        end else if (fell) begin
            SAMPLE_LEFT = ~charge_q;
            SAMPLE_VALID = 1'b1;
            charge_q = charge_q + 16'h0001;
        end
    end
endmodule : ccd_sensor_model

// ==== verification/ccd_clocking_sequencer_tb.sv ====
// Bench: frames in both split modes, FIFO stall, flush order and layout flags
`timescale 1ns/1ps
`include "ccd_params.svh"
module ccd_clocking_sequencer_tb;
    localparam int SET = 2;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic par = 1'b0;
    logic hold = 1'b0;
    logic pix_ready = 1'b1;
    logic [31:0] int_cyc = 32'h0000_0000;
    logic [15:0] line_pix = 16'h0080;
    logic [15:0] lines = 16'h0038;
    logic [15:0] samp, pix_data;
    logic samp_v, v1, v2, h1a, h1b, h2, lg, xg, pg, fd, rg, stb, dl, busy, pix_valid;
    logic v1_q, v2_q, h1a_q, lg_q;
    logic stb_q = 1'b0;
    logic [1:0] region;
    logic [31:0] seed = 32'h0000_f683;
    logic [31:0] rseed = 32'h0000_f683;
    int err_count = 0;
    int checks_done = 0;
    int ph, gap, ic, half, pix, ln, n_v1, n_xg, n_stb, n_rg, n_fl, n_dump, rx;
    initial begin
        forever #50 mclk = ~mclk;
    end
    ccd_sensor_model sensor (.MCLK(mclk), .RESET(reset), .LAST_HORIZONTAL_GATE(lg),
        .SAMPLE_LEFT(samp), .SAMPLE_VALID(samp_v));
    ccd_clocking_sequencer #(.WIDTH(16), .DEPTH(32), .SETTLE(SET)) dut (
        .MCLK(mclk), .RESET(reset), .START(start), .PARALLEL(par), .INT_CYCLES(int_cyc),
        .LINE_PIX(line_pix), .FRAME_LINES(lines), .SAMPLE_LEFT(samp), .SAMPLE_VALID(samp_v),
        .VERTICAL_PHASE_ONE(v1), .VERTICAL_PHASE_TWO(v2), .HORIZ_PHASE_ONE_A(h1a),
        .HORIZ_PHASE_ONE_B(h1b), .HORIZ_PHASE_TWO(h2), .LAST_HORIZONTAL_GATE(lg),
        .HORIZONTAL_TRANSFER_GATE(xg), .PULSE_PURGE_GATE(pg), .FAST_DUMP_GATE(fd),
        .FLOATING_NODE_RESET(rg), .PIXEL_STROBE(stb), .REGION(region), .DARK_LINE(dl),
        .BUSY(busy), .PIX_DATA(pix_data), .PIX_VALID(pix_valid), .PIX_READY(pix_ready));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    function automatic ccd_pkg::region_e exp_reg(input int i);
        if (i < `DUMMY_PIX) return ccd_pkg::RG_DUMMY;
        if (i < `DUMMY_PIX + `DARK_PIX) return ccd_pkg::RG_DARK;
        if (i < `DUMMY_PIX + `DARK_PIX + `BUFFER_PIX) return ccd_pkg::RG_BUFFER;
        return ccd_pkg::RG_ACTIVE;
    endfunction : exp_reg
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk_val
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic wrap_up;
        $display("Counts: %0d checks, %0d mismatches", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    always @(posedge mclk) begin
        #1;
        rseed = xs(rseed);
        pix_ready = !hold && rseed[1:0] != 2'b00;
    end
    always @(posedge mclk) begin
        if (!reset) begin
            if (pg || fd) chk_bit("purge_in_v2", 1'b1, v2 && ph == 1);
            if (fd) n_dump++;
            case (ph)
                0: if (v2 && busy) begin
                    chk_bit("flush_v1_low", 1'b0, v1);
                    ph = 1;
                    n_fl++;
                end
                1: if (!v2) begin
                    ph = 2;
                    gap = 0;
                end
                // One cycle of margin for where the count starts
                2: if (v1 || v2) begin
                    chk_bit("quiet_gap", 1'b1, v1 && gap >= SET + ic - 1);
                    ph = 3;
                end else gap++;
                default: if (v2_q && !v2) chk_bit("h1a_v2_fall", 1'b1, h1a && h1a_q);
            endcase
            if (v1 && !v1_q) n_v1++;
            if (xg) n_xg++;
            if (rg) n_rg++;
            if (pix_valid && pix_ready) begin
                chk_val("pix_data", 32'(rx[15:0]), 32'(pix_data));
                rx++;
            end
            // Reset gate follows in the cycle after the strobe
            if (stb_q) chk_bit("rg_pulse", 1'b1, rg);
            if (stb) begin
                n_stb++;
                chk_bit("gate_fell", 1'b1, lg_q && !lg);
                chk_val("region", 32'(exp_reg(pix)), 32'(region));
                chk_bit("dark_line", ln < `DARK_LINES_START || ln >= lines - `DARK_LINES_END, dl);
                pix++;
                if (pix == half) begin
                    pix = 0;
                    ln++;
                end
            end
        end
        v1_q = v1;
        v2_q = v2;
        h1a_q = h1a;
        lg_q = lg;
        stb_q = stb;
    end
    task automatic frame(input logic p, input logic [31:0] icyc, input logic stall);
        int n;
        int target;
        // Keep every input change off the clock edge
        #1;
        seed = xs(seed);
        par = p;
        int_cyc = icyc;
        line_pix = 16'(130 + 2 * (seed % 6));
        lines = 16'(56 + seed[10:8]);
        ic = icyc == 0 ? 1 : int'(icyc);
        half = line_pix / 2;
        {ph, pix, ln, n_v1, n_xg, n_stb, n_rg, n_fl, n_dump} = '0;
        target = rx + lines * half;
        hold = stall;
        start = 1'b1;
        @(posedge mclk);
        #1 start = 1'b0;
        repeat (40) @(posedge mclk);
        // Second request while busy must not restart the flush
        #1 start = 1'b1;
        @(posedge mclk);
        #1 start = 1'b0;
        if (stall) begin
            repeat (760) @(posedge mclk);
            chk_val("stall_fill", 32, n_stb);
            hold = 1'b0;
        end
        n = 0;
        while ((busy !== 1'b0 || rx != target) && n < 30000) begin
            @(posedge mclk);
            n++;
        end
        if (n == 30000) begin
            err_count++;
            wrap_up();
        end
        chk_val("lines", lines, n_v1);
        chk_val("xfer", p ? lines : 0, n_xg);
        chk_val("pixels", lines * half, n_stb);
        chk_val("resets", lines * half, n_rg);
        chk_val("flushes", 1, n_fl);
        chk_bit("dump_used", 1'b1, n_dump > 0);
        $display("Frame parallel=%0d done, mismatches %0d", p, err_count);
    endtask : frame
    initial begin
        repeat (12) @(posedge mclk);
        #1 reset = 1'b0;
        chk_val("reset_pins", 32'h0000_0340, 32'({v1, v2, h1a, h1b, h2, lg, xg, pg, fd, rg,
            busy, pix_valid}));
        frame(1'b0, 32'h0000_0000, 1'b1);
        seed = xs(seed);
        frame(1'b1, 32'h0000_0005 + (seed & 32'h0000_001f), 1'b0);
        wrap_up();
    end
endmodule : ccd_clocking_sequencer_tb
